// ### design/pdmc_params.svh
// timing counts, ratios and reset values for the microphone capture block
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH

// system clock rate in hertz
`define PDMC_CLK_HZ        100000000
// microphone clock rates in hertz
`define PDMC_MCLK_LOW_HZ   1024000
`define PDMC_MCLK_HIGH_HZ  3072000
// width of the phase accumulator that makes the microphone clock
`define PDMC_NCO_W         24
// decimation ratios, microphone bits per output sample
`define PDMC_RATIO_LOW_8K  9'd128
`define PDMC_RATIO_LOW_16K 9'd64
`define PDMC_RATIO_HI_8K   9'd384
`define PDMC_RATIO_HI_16K  9'd192
`define PDMC_RATIO_HI_48K  9'd64
// edge choice after reset: one bit per channel, high captures on rising
`define PDMC_EDGE_RST      4'h5
// sample width and voice buffer depth
`define PDMC_SAMPLE_W      16
`define PDMC_FIFO_DEPTH    32
// half-period bounds in system cycles, used by the checks
`define PDMC_HP_HI_MIN     8'd16
`define PDMC_HP_HI_MAX     8'd17
`define PDMC_HP_LO_MIN     8'd48
`define PDMC_HP_LO_MAX     8'd49

`endif

// ### design/pdmc_pkg.sv
// types shared by the microphone capture block
`default_nettype none

package pdmc_pkg;

    // sample rate set by the primary time-division port
    typedef enum logic [1:0] {
        RATE_NONE,
        RATE_8K,
        RATE_16K,
        RATE_48K
    } pdmc_rate_e;

    // one decimated sample tagged with its microphone channel
    typedef struct packed {
        logic [1:0]  chan;
        logic [15:0] data;
    } pdmc_sample_s;

endpackage : pdmc_pkg

`default_nettype wire

// ### design/pdmc_decim.sv
// boxcar decimator: counts ones over a ratio and dumps a signed sample
`default_nettype none

module pdmc_decim #(
    parameter int CNT_W = 9,
    parameter int OUT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             clear,
    input  wire logic             bit_valid,
    input  wire logic             bit_in,
    input  wire logic [CNT_W-1:0] ratio,
    output logic      [OUT_W-1:0] sample,
    output logic                  sample_valid
);
    localparam int PAD = OUT_W - CNT_W - 1;

    logic [CNT_W-1:0] cnt;        // bits seen in this window
    logic [CNT_W-1:0] ones;       // ones seen in this window
    logic [CNT_W-1:0] next_ones;  // ones including the new bit
    logic [CNT_W:0]   diff;       // ones minus half the window, signed
    logic             last;       // this bit closes the window

    assign next_ones = ones + CNT_W'(bit_in);
    assign diff      = {1'b0, next_ones} - {2'b00, ratio[CNT_W-1:1]};
    assign last      = (cnt == ratio - CNT_W'(1));

    // window counter and dump; clear wins so a stale window never dumps
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt          <= '0;
            ones         <= '0;
            sample       <= '0;
            sample_valid <= 1'b0;
        end else if (clear) begin
            cnt          <= '0;
            ones         <= '0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= bit_valid & last;
            if (bit_valid & last) begin
                cnt    <= '0;
                ones   <= '0;
                sample <= {diff, {PAD{1'b0}}};
            end else if (bit_valid) begin
                cnt  <= cnt + CNT_W'(1);
                ones <= next_ones;
            end
        end
    end

endmodule : pdmc_decim

`default_nettype wire

// ### design/pdmc_fifo.sv
// flip-flop fifo with valid and ready on both sides
`default_nettype none

module pdmc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [AW:0]      wr_ptr;       // write pointer with wrap bit
    logic [AW:0]      rd_ptr;       // read pointer with wrap bit
    logic             push;
    logic             pop;

    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage is written only, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

endmodule : pdmc_fifo

`default_nettype wire

// ### design/pdmc_top.sv
// capture of four pulse-density microphones on two shared data lines
`include "pdmc_params.svh"
`default_nettype none

module pdmc_top
    import pdmc_pkg::*;
#(
    parameter int NCH   = 4,
    parameter int DEPTH = `PDMC_FIFO_DEPTH
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic [1:0]  TDM_RATE,
    input  wire logic        PROC_WIDEBAND,
    input  wire logic [3:0]  MIC_ENABLE,
    input  wire logic        CFG_EDGE_WR,
    input  wire logic [3:0]  CFG_EDGE,
    input  wire logic [1:0]  VOICE_SEL,
    input  wire logic [3:0]  TDM_ROUTE,
    input  wire logic        MIC_DATA_IN_FIRST,
    input  wire logic        MIC_DATA_IN_SECOND,
    output logic             MIC_CLOCK_OUT,
    output logic [15:0]      VOICE_DATA,
    output logic [1:0]       VOICE_CHANNEL,
    output logic             VOICE_VALID,
    input  wire logic        VOICE_READY,
    output logic             VOICE_OVERRUN,
    output logic [3:0]       AEC_ACTIVE,
    output logic [63:0]      TDM_SAMPLE,
    output logic [3:0]       TDM_VALID
);

    ////////////////////////////////////////////////////////////////////////
    // rate decoding

    localparam int NW = `PDMC_NCO_W;
    // accumulator steps: two carries per microphone clock period
    localparam logic [NW-1:0] INC_LOW = NW'((64'd2 * `PDMC_MCLK_LOW_HZ
        * (64'd1 << NW)) / `PDMC_CLK_HZ);
    localparam logic [NW-1:0] INC_HIGH = NW'((64'd2 * `PDMC_MCLK_HIGH_HZ
        * (64'd1 << NW)) / `PDMC_CLK_HZ);

    pdmc_rate_e rate;          // decoded port rate
    logic       fast_clk;      // microphone clock at the high rate
    logic [8:0] ratio;         // decimation ratio for every channel
    logic [2:0] cfg_key;       // rate setting seen last cycle
    logic       restart;       // rate setting changed
    logic       run;           // any microphone enabled

    assign rate     = pdmc_rate_e'(TDM_RATE);
    assign fast_clk = (rate == RATE_NONE) || (rate == RATE_48K);
    assign run      = |MIC_ENABLE;
    assign restart  = (cfg_key != {TDM_RATE, PROC_WIDEBAND});

    // no port rate runs from the local clock and passes 48 kHz audio
    assign ratio = (rate == RATE_NONE) ? `PDMC_RATIO_HI_48K :
                   fast_clk ? (PROC_WIDEBAND ? `PDMC_RATIO_HI_16K
                                             : `PDMC_RATIO_HI_8K) :
                   (PROC_WIDEBAND ? `PDMC_RATIO_LOW_16K
                                  : `PDMC_RATIO_LOW_8K);

    // remember the setting so a change flushes half-built samples
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_key <= '0;
        end else begin
            cfg_key <= {TDM_RATE, PROC_WIDEBAND};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // microphone clock generator

    logic [NW-1:0] acc;        // phase accumulator
    logic [NW:0]   sum;        // accumulator plus step, with carry
    logic          carry;      // half period done, clock toggles
    logic          mclk_rise;  // clock goes high this cycle
    logic          mclk_fall;  // clock goes low this cycle

    // the rate is not a whole divisor of the system clock, so edges
    // jitter by one cycle; the average frequency falls short by the truncation of the step
    assign sum       = {1'b0, acc} + {1'b0, fast_clk ? INC_HIGH : INC_LOW};
    assign carry     = sum[NW] & run & ~restart;
    assign mclk_rise = carry & ~MIC_CLOCK_OUT;
    assign mclk_fall = carry & MIC_CLOCK_OUT;

    // clock stays low while all microphones are off, which also idles
    // any pre-amplifier hanging on the same pin
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            acc           <= '0;
            MIC_CLOCK_OUT <= 1'b0;
        end else if (!run || restart) begin
            acc           <= '0;
            MIC_CLOCK_OUT <= 1'b0;
        end else begin
            acc           <= sum[NW-1:0];
            MIC_CLOCK_OUT <= MIC_CLOCK_OUT ^ carry;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data pins and edge choice

    logic [1:0] din_meta;      // first synchroniser stage
    logic [1:0] din_sync;      // second stage, safe to read
    logic [3:0] edge_cfg;      // high: channel captured on rising edge

    // two flops on each data pin before anything looks at it
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            din_meta <= '0;
            din_sync <= '0;
        end else begin
            din_meta <= {MIC_DATA_IN_SECOND, MIC_DATA_IN_FIRST};
            din_sync <= din_meta;
        end
    end

    // edge choice written by the host or by the boot loader
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            edge_cfg <= `PDMC_EDGE_RST;
        end else if (CFG_EDGE_WR) begin
            edge_cfg <= CFG_EDGE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel capture and decimation

    logic [NCH-1:0]  bit_stb;                // channel takes a bit
    logic [NCH-1:0]  bit_val;                // the bit it takes
    logic [NCH-1:0]  dec_clr;                // flush a channel
    logic [15:0]     dec_sample [NCH];       // decimated samples
    logic [NCH-1:0]  dec_valid;              // sample ready, one cycle

    // channels 0,1 share the first line, 2,3 the second; at an edge the
    // synchronised level is what the microphone held through the half
    // period just ending, because the other one had released the line
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            assign bit_stb[gi] = MIC_ENABLE[gi] &
                (edge_cfg[gi] ? mclk_rise : mclk_fall);
            assign bit_val[gi] = din_sync[gi/2];
            assign dec_clr[gi] = restart | ~MIC_ENABLE[gi];

            pdmc_decim #(
                .CNT_W (9),
                .OUT_W (`PDMC_SAMPLE_W)
            ) u_decim (
                .clk          (CLK),
                .resetn       (RESETN),
                .clear        (dec_clr[gi]),
                .bit_valid    (bit_stb[gi]),
                .bit_in       (bit_val[gi]),
                .ratio        (ratio),
                .sample       (dec_sample[gi]),
                .sample_valid (dec_valid[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // voice selection and echo-cancel flag

    logic [1:0] voice_ch;      // channel feeding voice processing

    // selection follows the host the next cycle; a sample already in
    // the buffer keeps its old channel tag
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            voice_ch   <= '0;
            AEC_ACTIVE <= 4'h1;
        end else begin
            voice_ch   <= VOICE_SEL;
            AEC_ACTIVE <= 4'h1 << VOICE_SEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // voice path: pending slot, buffer, output stage

    pdmc_sample_s pend;        // sample waiting to enter the buffer
    logic         pend_valid;  // pending slot full
    logic         fifo_ready;  // buffer accepts the pending sample
    logic         new_voice;   // selected channel produced a sample
    logic         out_take;    // output stage loads from the buffer
    pdmc_sample_s fifo_out;    // head of the buffer
    logic         fifo_valid;  // buffer not empty

    assign new_voice = dec_valid[voice_ch];
    assign out_take  = fifo_valid & (~VOICE_VALID | VOICE_READY);

    // a full buffer stalls the slot; a sample arriving while it is
    // stalled is lost and flagged, since a microphone cannot wait
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pend          <= '0;
            pend_valid    <= 1'b0;
            VOICE_OVERRUN <= 1'b0;
        end else begin
            VOICE_OVERRUN <= new_voice & pend_valid & ~fifo_ready;
            if (new_voice && (!pend_valid || fifo_ready)) begin
                pend       <= '{chan: voice_ch,
                                data: dec_sample[voice_ch]};
                pend_valid <= 1'b1;
            end else if (fifo_ready) begin
                pend_valid <= 1'b0;
            end
        end
    end

    pdmc_fifo #(
        .WIDTH ($bits(pdmc_sample_s)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .resetn    (RESETN),
        .in_valid  (pend_valid),
        .in_ready  (fifo_ready),
        .in_data   (pend),
        .out_valid (fifo_valid),
        .out_ready (out_take),
        .out_data  (fifo_out)
    );

    // registered output so the ports come straight from flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            VOICE_DATA    <= '0;
            VOICE_CHANNEL <= '0;
            VOICE_VALID   <= 1'b0;
        end else if (out_take) begin
            VOICE_DATA    <= fifo_out.data;
            VOICE_CHANNEL <= fifo_out.chan;
            VOICE_VALID   <= 1'b1;
        end else if (VOICE_READY) begin
            VOICE_VALID   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port routing of the unselected paths

    logic [NCH-1:0] tdm_hit;   // sample goes to the port this cycle

    generate
        for (gi = 0; gi < NCH; gi++) begin : g_tdm
            assign tdm_hit[gi] = dec_valid[gi] & TDM_ROUTE[gi] &
                                 (voice_ch != 2'(gi));

            // held until the next sample of the same channel
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    TDM_SAMPLE[gi*16 +: 16] <= '0;
                    TDM_VALID[gi]           <= 1'b0;
                end else begin
                    TDM_VALID[gi] <= tdm_hit[gi];
                    if (tdm_hit[gi]) begin
                        TDM_SAMPLE[gi*16 +: 16] <= dec_sample[gi];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] hp_cnt;        // cycles since the last clock toggle
    logic       hp_seen;       // a toggle happened at this rate

    // half-period measure for the clock-rate checks
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            hp_cnt  <= '0;
            hp_seen <= 1'b0;
        end else if (!run || restart) begin
            hp_cnt  <= '0;
            hp_seen <= 1'b0;
        end else begin
            hp_cnt  <= carry ? 8'h01 : hp_cnt + 8'h01;
            hp_seen <= hp_seen | carry;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    hi_half_period_a: assert property (
        (carry && hp_seen && fast_clk) |->
            (hp_cnt >= `PDMC_HP_HI_MIN) && (hp_cnt <= `PDMC_HP_HI_MAX))
        else $error("fast microphone clock half period wrong");

    lo_half_period_a: assert property (
        (carry && hp_seen && !fast_clk) |->
            (hp_cnt >= `PDMC_HP_LO_MIN) && (hp_cnt <= `PDMC_HP_LO_MAX))
        else $error("slow microphone clock half period wrong");

    no_port_rate_a: assert property (
        (rate == RATE_NONE) |-> (fast_clk && ratio == 9'd64))
        else $error("no port rate must pass 48 kHz from fast clock");

    clock_keeps_running_a: assert property (
        (run && !restart && hp_seen) |->
            ##[1:60] $changed(MIC_CLOCK_OUT) || !run || restart)
        else $error("microphone clock stalled while enabled");

    edge_split_a: assert property (
        (edge_cfg[0] != edge_cfg[1] && MIC_ENABLE[1:0] == 2'b11)
            |-> !(bit_stb[0] && bit_stb[1]))
        else $error("two channels of one line took the same edge");

    edge_cfg_load_a: assert property (
        CFG_EDGE_WR |=> (edge_cfg == $past(CFG_EDGE)))
        else $error("edge choice not taken from write");

    one_voice_path_a: assert property (
        $onehot(AEC_ACTIVE) && AEC_ACTIVE[voice_ch])
        else $error("echo cancel not on exactly the voice path");

    voice_follow_a: assert property (
        $changed(VOICE_SEL) |=> (voice_ch == $past(VOICE_SEL)) &&
            (AEC_ACTIVE == 4'h1 << $past(VOICE_SEL)))
        else $error("voice selection did not follow host");

    port_excludes_voice_a: assert property (
        (TDM_VALID & 4'(1 << $past(voice_ch))) == 4'h0)
        else $error("voice path also sent to port");

    disabled_silent_a: assert property (
        !MIC_ENABLE[2] |-> !bit_stb[2] ##1 !dec_valid[2])
        else $error("disabled channel produced data");

endmodule : pdmc_top

`default_nettype wire

// ### testbench/pdmc_mic_model.sv
// model of four pulse-density microphones on two lines
`default_nettype none

module pdmc_mic_model (
    input  wire logic            mic_clock,
    input  wire logic [3:0][1:0] pat,
    output logic                 line_first,
    output logic                 line_second
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] bits;  // last bit of each microphone
    logic       phase; // flips each clock for the alternating pattern

    // pattern 0 all low, 1 all high, 2 alternating
    function automatic logic next_bit(input logic [1:0] p);
        return (p == 2'd2) ? phase : p[0];
    endfunction : next_bit

    initial begin
        line_first = 1'b0;
        line_second = 1'b0;
        bits = 4'h0;
        phase = 1'b0;
    end

    // low half: rising-edge mics drive, their partners let go
    always @(negedge mic_clock) begin
        phase = ~phase;
        bits[0] = next_bit(pat[0]);
        bits[2] = next_bit(pat[2]);
        line_first = bits[0];
        line_second = bits[2];
    end

    // high half: falling-edge mics drive for the coming fall
    always @(posedge mic_clock) begin
        bits[1] = next_bit(pat[1]);
        bits[3] = next_bit(pat[3]);
        line_first = bits[1];
        line_second = bits[3];
    end
endmodule : pdmc_mic_model

`default_nettype wire

// ### testbench/pdmc_top_tb.sv
// self-checking bench for the microphone capture block
`include "pdmc_params.svh"
`default_nettype none

module pdmc_top_tb import pdmc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic            clk, resetn, edge_wr, wideband, ready;
    logic [1:0]      rate, sel, vch;
    logic [3:0]      enable, edge_cfg, route, aec, tvalid;
    logic            line1, line2, mclk, mclk_q, vvalid, ovr;
    logic [15:0]     vdata;
    logic [63:0]     tsample;
    logic [3:0][1:0] pat;  // pattern per microphone
    int miscompares, checked, ratio, hp, ovr_seen;
    int tcnt[4], vcnt[4];  // samples seen per channel
    bit run, hp_chk, fast;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // small buffer so an overrun is reached in a short run
    pdmc_top #(.DEPTH(4)) u_pdmc_top (
        .CLK(clk), .RESETN(resetn), .TDM_RATE(rate),
        .PROC_WIDEBAND(wideband), .MIC_ENABLE(enable),
        .CFG_EDGE_WR(edge_wr), .CFG_EDGE(edge_cfg), .VOICE_SEL(sel),
        .TDM_ROUTE(route), .MIC_DATA_IN_FIRST(line1),
        .MIC_DATA_IN_SECOND(line2), .MIC_CLOCK_OUT(mclk),
        .VOICE_DATA(vdata), .VOICE_CHANNEL(vch), .VOICE_VALID(vvalid),
        .VOICE_READY(ready), .VOICE_OVERRUN(ovr), .AEC_ACTIVE(aec),
        .TDM_SAMPLE(tsample), .TDM_VALID(tvalid));

    pdmc_mic_model u_pdmc_mic_model (
        .mic_clock(mclk), .pat(pat),
        .line_first(line1), .line_second(line2));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // channel c hears the mic of its line that drives its chosen edge
    function automatic logic [15:0] exp_val(input int c);
        int m, ones;
        m = (c / 2) * 2 + (edge_cfg[c] ? 0 : 1);
        ones = (pat[m] == 2'd1) ? ratio : (pat[m] == 2'd0 ? 0 : ratio / 2);
        return 16'((ones - ratio / 2) * 64);
    endfunction : exp_val

    // 0: every path has two samples, 1: an overrun was seen
    function automatic bit done(input int what);
        bit ok;
        if (what == 1)
            return ovr_seen > 0;
        ok = vcnt[sel] >= 2;
        for (int c = 0; c < 4; c++)
            if (c != sel && tcnt[c] < 2)
                ok = 0;
        return ok;
    endfunction : done

    task automatic wait_for(input int what);
        int n;
        n = 0;
        while (!done(what)) begin
            @(posedge clk);
            if (tcnt[sel ^ 2'd1] > 0)
                hp_chk = 1;
            if (++n > 40000) begin
                miscompares++;
                complete_run;
            end
        end
    endtask : wait_for

    ////////////////////////////////////////
    // the first sample per channel may hold a partial window: skipped
    always @(posedge clk) begin
        if (run) begin
            for (int c = 0; c < 4; c++)
                if (tvalid[c]) begin
                    if (tcnt[c] > 0)
                        check(tsample[16*c +: 16], exp_val(c));
                    tcnt[c]++;
                end
            check(16'(tvalid & aec), 16'h0);
            if (vvalid && ready) begin
                check(16'(vch), 16'(sel));
                if (vcnt[vch] > 0)
                    check(vdata, exp_val(vch));
                vcnt[vch]++;
            end
            if (ovr)
                ovr_seen++;
        end
        if (mclk !== mclk_q) begin
            if (hp_chk)
                check(16'(fast ? (hp + 1 >= `PDMC_HP_HI_MIN &&
                    hp + 1 <= `PDMC_HP_HI_MAX) : (hp + 1 >= `PDMC_HP_LO_MIN
                    && hp + 1 <= `PDMC_HP_LO_MAX)), 16'h1);
            hp = 0;
        end else
            hp++;
        mclk_q = mclk;
    end

    // one rate setting with random patterns, edges and voice choice
    task automatic run_mode(input logic [1:0] r, input logic wb,
                            input int rt, input bit f, input bit stall);
        @(posedge clk);
        #1 run = 0;
        hp_chk = 0;
        for (int c = 0; c < 4; c++)
            pat[c] = 2'($urandom % 3);
        rate = r;
        wideband = wb;
        sel = 2'($urandom);
        edge_cfg = 4'($urandom);
        edge_wr = 1'b1;
        @(posedge clk);
        #1 edge_wr = 1'b0;
        check(16'(aec), 16'(1 << sel));
        ratio = rt;
        fast = f;
        repeat (20) @(posedge clk);
        #1 tcnt = '{4{0}};
        vcnt = '{4{0}};
        ovr_seen = 0;
        run = 1;
        if (stall) begin
            ready = 1'b0;
            wait_for(1); // buffer full, next sample lost
            @(posedge clk);
            #1 ready = 1'b1;
            repeat (20) @(posedge clk);
            #1 check(16'(vvalid), 16'h0);
        end
        wait_for(0);
    endtask : run_mode

    initial begin
        resetn = 1'b0;
        {edge_wr, wideband, rate, sel, edge_cfg} = '0;
        {enable, route, ready, mclk_q, hp} = {4'hf, 4'hf, 1'b1, 1'b0, 32'd0};
        void'($urandom(45));
        repeat (3) @(posedge clk);
        check(16'({mclk, vvalid, aec}), 16'h1);
        #1 resetn = 1'b1;
        run_mode(RATE_8K, 1'b0, 128, 0, 0);
        run_mode(RATE_16K, 1'b1, 64, 0, 0);
        run_mode(RATE_48K, 1'b0, 384, 1, 0);
        run_mode(RATE_48K, 1'b1, 192, 1, 0);
        run_mode(RATE_NONE, 1'($urandom), 64, 1, 1);
        #1 hp_chk = 0;
        enable = 4'h0;
        repeat (5) @(posedge clk);
        #1 hp = 0;
        repeat (300) @(posedge clk);
        #1 check(16'(hp), 16'd300);
        complete_run;
    end
endmodule : pdmc_top_tb

`default_nettype wire
